// >>> rtl/two_wire_slave_port.sv
/*
  Two-wire bus slave port: condition detection, address check, byte
  receive and transmit with acknowledge, and handover to the core clock.
  Assumes an external master with pull-ups on both lines, a link_clk that
  oversamples the bus clock several times, and same-clock core inputs.
*/
// Contract
// - Slave only; never drives clock line
// - Data change with clock high is condition
// - Data falling, clock high: START
// - Data rising, clock high: STOP ends transfer
// - Eight bits then ninth acknowledge bit
// - Any number of bytes per transfer
// - Works at 100kHz and 400kHz
// - Acknowledge low through whole clock high
// - Master not-acknowledge: release data line
// - Write: acknowledge every received byte
// - Repeated START ends and restarts transfer
// - Hardware address check after first byte
// - Read: drive data, clock stays input
// - Match fixed or configured address only
// - Last control bit: 1 read, 0 write
// - Check type code, address, direction, then acknowledge
// - Own address set from nonvolatile value
// - Mismatch: no acknowledge, idle until START
// - Nonvolatile write busy: ignore bus
`default_nettype none

`include "tws_defines.svh"

module two_wire_slave_port (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link sampling clock
  input wire logic link_clk,
  // Bus pins, clock line is input only
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Configuration from nonvolatile logic
  input wire tws_pkg::dev_addr_t nv_dev_addr,
  input wire logic nv_busy,
  // Byte to transmit
  input wire tws_pkg::byte_t tx_byte,
  input wire logic tx_load,
  output logic tx_ready,
  output logic tx_taken,
  // Received bytes and transfer events
  output tws_pkg::byte_t rx_byte,
  output logic rx_valid,
  output logic addr_hit,
  output logic addr_rd,
  output logic xfer_end
);

  import tws_pkg::*;

  // ----------------------------------------------------------------
  // Link domain reset
  // ----------------------------------------------------------------
  logic lrst_s1_r; // Reset synchroniser, first stage
  logic lrst_r; // Reset as seen by link logic

  // Carry the core reset into the link domain
  always_ff @(posedge link_clk) begin
    lrst_s1_r <= sys_rst;
    lrst_r <= lrst_s1_r;
  end

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  logic scl_s1_r; // First stages, read only by second stages
  logic sda_s1_r;
  logic scl_s_r; // Synchronised lines
  logic sda_s_r;
  logic scl_d_r; // One sample older
  logic sda_d_r;
  logic busy_s1_r; // Busy level crossing
  logic busy_s_r;

  // Two flops per pin before any decode; idle lines read as high
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      scl_s1_r <= 1'b1;
      sda_s1_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_s1_r <= 1'b0;
      busy_s_r <= 1'b0;
    end else begin
      scl_s1_r <= scl_i;
      sda_s1_r <= sda_i;
      scl_s_r <= scl_s1_r;
      sda_s_r <= sda_s1_r;
      scl_d_r <= scl_s_r;
      sda_d_r <= sda_s_r;
      busy_s1_r <= nv_busy;
      busy_s_r <= busy_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus condition decode
  // ----------------------------------------------------------------
  logic scl_high_w; // Clock high on both samples
  logic start_w;
  logic stop_w;
  logic scl_rise_w;
  logic scl_fall_w;

  // Oversampling keeps this valid for both 100kHz and 400kHz buses
  assign scl_high_w = scl_s_r & scl_d_r;
  // Data edges inside clock high are conditions, never data
  assign start_w = scl_high_w & sda_d_r & ~sda_s_r;
  assign stop_w = scl_high_w & ~sda_d_r & sda_s_r;
  // Bits sampled on the rising edge, driven after the falling one
  assign scl_rise_w = scl_s_r & ~scl_d_r;
  assign scl_fall_w = ~scl_s_r & scl_d_r;

  // ----------------------------------------------------------------
  // Address recognition
  // ----------------------------------------------------------------
  link_state_t st_r; // Bus state
  link_state_t st_nxt;
  logic [3:0] cnt_r; // Bits received or driven in this byte
  logic [3:0] cnt_nxt;
  byte_t sh_r; // Receive shift register
  byte_t sh_nxt;
  byte_t tsh_r; // Transmit shift register
  byte_t tsh_nxt;
  logic rd_r; // Transfer direction, high for read
  logic rd_nxt;
  logic ackok_r; // Master acknowledged the last sent byte
  logic ackok_nxt;
  logic oe_r; // Data line pulled low
  logic oe_nxt;
  logic ev_ld_r; // Event load pulse
  logic ev_ld_nxt;
  ev_word_t ev_r; // Event kind and byte
  ev_word_t ev_nxt;
  dev_addr_t dev_cfg; // Configured address in link domain
  byte_t tx_hold; // Next byte to send, link domain copy
  logic code_ok_w;
  logic addr_ok_w;
  logic hit_w;
  logic byte_done_w;
  logic addressed_w;

  assign byte_done_w = (cnt_r == `TWS_BYTE_BITS);
  // Device type code first, then address bits
  assign code_ok_w = (sh_r[`TWS_CODE_HI:`TWS_CODE_LO] == `TWS_TYPE_CODE);
  // Either the fixed address or the one loaded from nonvolatile store
  assign addr_ok_w = (sh_r[`TWS_ADDR_HI:`TWS_ADDR_LO] == `TWS_FIXED_ADDR)
                   | (sh_r[`TWS_ADDR_HI:`TWS_ADDR_LO] == dev_cfg);
  // A busy nonvolatile write blocks the address acknowledge
  assign hit_w = code_ok_w & addr_ok_w & ~busy_s_r;
  assign addressed_w = (st_r != ST_IDLE) & (st_r != ST_ADDR);

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  // Conditions win over bit traffic in any state
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tsh_nxt = tsh_r;
    rd_nxt = rd_r;
    ackok_nxt = ackok_r;
    oe_nxt = oe_r;
    ev_ld_nxt = 1'b0;
    ev_nxt = ev_r;
    if (start_w) begin
      // Repeated START closes the current transfer first
      if (addressed_w) begin
        ev_ld_nxt = 1'b1;
        ev_nxt = {`TWS_EV_END, 8'h00};
      end
      // Busy device stays deaf until the next START
      st_nxt = busy_s_r ? ST_IDLE : ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_w) begin
      if (addressed_w) begin
        ev_ld_nxt = 1'b1;
        ev_nxt = {`TWS_EV_END, 8'h00};
      end
      st_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // Waiting for START; lines ignored
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          // Shift in MSB first on rising clock
          if (scl_rise_w && !byte_done_w) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall_w && byte_done_w) begin
            if (st_r == ST_RX) begin
              // Every received data byte is acknowledged
              oe_nxt = 1'b1;
              st_nxt = ST_RX_ACK;
              ev_ld_nxt = 1'b1;
              ev_nxt = {`TWS_EV_RXBYTE, sh_r};
            end else if (hit_w) begin
              // Pull low for the whole ninth clock
              oe_nxt = 1'b1;
              rd_nxt = (sh_r[`TWS_DIR_BIT] == `TWS_DIR_READ);
              st_nxt = ST_ADDR_ACK;
              ev_ld_nxt = 1'b1;
              ev_nxt = {`TWS_EV_MATCH, sh_r};
            end else begin
              // Not ours: stay released and sleep
              oe_nxt = 1'b0;
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK: begin
          // Acknowledge ends with the falling clock
          if (scl_fall_w) begin
            if (st_r == ST_ADDR_ACK && rd_r) begin
              // First read byte goes out at once
              tsh_nxt = tx_hold;
              oe_nxt = ~tx_hold[7];
              cnt_nxt = `TWS_FIRST_BIT;
              st_nxt = ST_TX;
              ev_ld_nxt = 1'b1;
              ev_nxt = {`TWS_EV_TXBYTE, tx_hold};
            end else begin
              // No byte limit: keep receiving until a condition
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              st_nxt = ST_RX;
            end
          end
        end
        ST_TX: begin
          // Next bit placed while the clock is low
          if (scl_fall_w) begin
            if (byte_done_w) begin
              oe_nxt = 1'b0;
              st_nxt = ST_TX_ACK;
            end else begin
              tsh_nxt = {tsh_r[6:0], 1'b0};
              oe_nxt = ~tsh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_TX_ACK: begin
          // Sample the master answer, act on the fall
          if (scl_rise_w) begin
            ackok_nxt = ~sda_s_r;
          end else if (scl_fall_w) begin
            if (ackok_r) begin
              tsh_nxt = tx_hold;
              oe_nxt = ~tx_hold[7];
              cnt_nxt = `TWS_FIRST_BIT;
              st_nxt = ST_TX;
              ev_ld_nxt = 1'b1;
              ev_nxt = {`TWS_EV_TXBYTE, tx_hold};
            end else begin
              // Last byte refused: leave the line high for STOP
              oe_nxt = 1'b0;
              st_nxt = ST_IDLE;
            end
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // State and shift registers
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tsh_r <= 8'h00;
      rd_r <= 1'b0;
      ackok_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tsh_r <= tsh_nxt;
      rd_r <= rd_nxt;
      ackok_r <= ackok_nxt;
    end
  end

  // Pin drive: open drain, data value tied low, clock never driven
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      sda_oe <= oe_nxt;
      sda_o <= 1'b0;
      oe_r <= oe_nxt;
    end
  end

  // Event word launched toward the core
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      ev_ld_r <= 1'b0;
      ev_r <= '0;
    end else begin
      ev_ld_r <= ev_ld_nxt;
      ev_r <= ev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Crossings
  // ----------------------------------------------------------------
  dev_addr_t cfg_sent_r; // Address last handed to link side
  logic cfg_ready;
  logic cfg_ld_w;
  ev_word_t ev_core;
  logic ev_pulse;

  // Resend the address whenever the stored value moves
  assign cfg_ld_w = cfg_ready & (nv_dev_addr != cfg_sent_r);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_sent_r <= `TWS_FIXED_ADDR;
    end else if (cfg_ld_w) begin
      cfg_sent_r <= nv_dev_addr;
    end
  end

  // Configured address, core to link
  word_handoff #(.W(3)) u_cfg_xfer (
    .src_clk(core_clk),
    .src_rst(sys_rst),
    .src_ld(cfg_ld_w),
    .src_data(nv_dev_addr),
    .src_ready(cfg_ready),
    .dst_clk(link_clk),
    .dst_rst(lrst_r),
    .dst_data(dev_cfg),
    .dst_pulse()
  );

  // Transmit byte, core to link; must arrive before the byte is due
  word_handoff #(.W(8)) u_tx_xfer (
    .src_clk(core_clk),
    .src_rst(sys_rst),
    .src_ld(tx_load),
    .src_data(tx_byte),
    .src_ready(tx_ready),
    .dst_clk(link_clk),
    .dst_rst(lrst_r),
    .dst_data(tx_hold),
    .dst_pulse()
  );

  // Events, link to core; spacing of a bus bit leaves ample margin
  word_handoff #(.W(`TWS_EV_W)) u_ev_xfer (
    .src_clk(link_clk),
    .src_rst(lrst_r),
    .src_ld(ev_ld_r),
    .src_data(ev_r),
    .src_ready(),
    .dst_clk(core_clk),
    .dst_rst(sys_rst),
    .dst_data(ev_core),
    .dst_pulse(ev_pulse)
  );

  // ----------------------------------------------------------------
  // Core side event decode
  // ----------------------------------------------------------------
  logic [1:0] ev_kind_w;
  logic is_match_w;
  logic is_rx_w;
  logic is_tx_w;
  logic is_end_w;

  assign ev_kind_w = ev_core[`TWS_EV_W-1:8];
  assign is_match_w = ev_pulse & (ev_kind_w == `TWS_EV_MATCH);
  assign is_rx_w = ev_pulse & (ev_kind_w == `TWS_EV_RXBYTE);
  assign is_tx_w = ev_pulse & (ev_kind_w == `TWS_EV_TXBYTE);
  assign is_end_w = ev_pulse & (ev_kind_w == `TWS_EV_END);

  // One-cycle strobes and held data for the user
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      addr_hit <= 1'b0;
      addr_rd <= 1'b0;
      xfer_end <= 1'b0;
      tx_taken <= 1'b0;
    end else begin
      if (is_rx_w) begin
        rx_byte <= ev_core[7:0];
      end
      if (is_match_w) begin
        addr_rd <= ev_core[`TWS_DIR_BIT];
      end
      rx_valid <= is_rx_w;
      addr_hit <= is_match_w;
      xfer_end <= is_end_w;
      tx_taken <= is_tx_w;
    end
  end

endmodule : two_wire_slave_port

`default_nettype wire

// >>> pkg/tws_defines.svh
/*
  Constants of the two-wire slave port: control byte fields, fixed
  address, byte length and the codes of the events handed to the core.
  Assumes it is included by its bare name from packages and modules.
*/
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// ----------------------------------------------------------------
// Control byte layout
// ----------------------------------------------------------------
`define TWS_TYPE_CODE 4'hA
`define TWS_CODE_HI 7
`define TWS_CODE_LO 4
`define TWS_ADDR_HI 3
`define TWS_ADDR_LO 1
`define TWS_DIR_BIT 0
`define TWS_DIR_READ 1'h1
`define TWS_FIXED_ADDR 3'h0

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define TWS_BYTE_BITS 4'h8
`define TWS_FIRST_BIT 4'h1

// ----------------------------------------------------------------
// Event codes, link side to core side
// ----------------------------------------------------------------
`define TWS_EV_MATCH 2'h0
`define TWS_EV_RXBYTE 2'h1
`define TWS_EV_TXBYTE 2'h2
`define TWS_EV_END 2'h3
`define TWS_EV_W 10

`endif

// >>> pkg/tws_pkg.sv
/*
  Types of the two-wire slave port.
  Assumes tws_defines.svh sits on the include path.
*/
`default_nettype none

`include "tws_defines.svh"

package tws_pkg;

  // ----------------------------------------------------------------
  // Data types
  // ----------------------------------------------------------------
  typedef logic [7:0] byte_t;
  typedef logic [2:0] dev_addr_t;
  typedef logic [`TWS_EV_W-1:0] ev_word_t;

  // Link side bus states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } link_state_t;

endpackage : tws_pkg

`default_nettype wire

// >>> rtl/word_handoff.sv
/*
  Toggle handshake that carries one word from one clock domain to another.
  Assumes the source loads only while src_ready is high; loads at other
  times are ignored. Each domain brings its own synchronous reset.
*/
`default_nettype none

module word_handoff #(
  parameter int W = 8
) (
  // Source domain
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_ld,
  input wire logic [W-1:0] src_data,
  output logic src_ready,
  // Destination domain
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic [W-1:0] dst_data,
  output logic dst_pulse
);

  // ----------------------------------------------------------------
  // Source side
  // ----------------------------------------------------------------
  logic [W-1:0] hold_r; // Word held steady until acknowledged
  logic req_r; // Request toggle
  logic ack_s1_r; // Ack synchroniser, first stage
  logic ack_s2_r; // Ack synchroniser, second stage
  logic req_d_r; // Destination copy of request, also the ack
  logic take_w;

  assign take_w = src_ld & src_ready;

  // Capture and toggle; hold stays put while a word is in flight
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      hold_r <= '0;
      req_r <= 1'b0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      src_ready <= 1'b0;
    end else begin
      if (take_w) begin
        hold_r <= src_data;
        req_r <= ~req_r;
      end
      ack_s1_r <= req_d_r;
      ack_s2_r <= ack_s1_r;
      src_ready <= (req_r == ack_s2_r) & ~take_w;
    end
  end

  // ----------------------------------------------------------------
  // Destination side
  // ----------------------------------------------------------------
  logic req_s1_r; // Request synchroniser, first stage
  logic req_s2_r; // Request synchroniser, second stage
  logic new_w;

  assign new_w = req_s2_r ^ req_d_r;

  // Pick up the held word once the toggle has settled
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_d_r <= 1'b0;
      dst_data <= '0;
      dst_pulse <= 1'b0;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      req_d_r <= req_s2_r;
      if (new_w) begin
        dst_data <= hold_r;
      end
      dst_pulse <= new_w;
    end
  end

endmodule : word_handoff

`default_nettype wire

// >>> verification/tws_port_asserts.sv
/*
  Concurrent checks on the ports of two_wire_slave_port.
  Assumes the bind below; sees only the port signals of the block.
*/
`default_nettype none

module tws_port_checker (
  // Clocks and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  // Bus side
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Core side
  input wire logic tx_taken,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic addr_hit,
  input wire logic addr_rd,
  input wire logic xfer_end
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Clock line high at two link samples in a row
  sequence scl_high_s;
    scl_i ##1 scl_i;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The pull may only change while the clock line is low
  ack_steady_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    scl_high_s |-> $stable(sda_oe)) else $error("data pull moved with clock high");
  open_drain_a: assert property (@(posedge link_clk) disable iff (sys_rst)
    sda_oe |-> !sda_o) else $error("data line driven high");
  rst_quiet_a: assert property (@(posedge core_clk)
    sys_rst |=> !(rx_valid || addr_hit || xfer_end || tx_taken || tx_ready))
    else $error("core outputs active in reset");
  hit_acks_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    addr_hit |-> sda_oe) else $error("address hit without acknowledge");
  rx_acks_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_valid |-> sda_oe) else $error("byte received without acknowledge");
  hit_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    addr_hit |=> !addr_hit) else $error("address hit longer than one cycle");
  rx_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_valid |=> !rx_valid) else $error("receive pulse longer than one cycle");
  end_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    xfer_end |=> !xfer_end) else $error("end pulse longer than one cycle");
  tx_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tx_taken |-> addr_rd) else $error("byte sent outside a read");
endmodule : tws_port_checker

bind two_wire_slave_port tws_port_checker tws_port_checker_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .tx_taken(tx_taken), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .addr_hit(addr_hit), .addr_rd(addr_rd), .xfer_end(xfer_end)
);

`default_nettype wire

// >>> verification/bus_master.sv
/*
  Behavioural two-wire bus master, open-drain on both lines.
  Assumes pull-ups outside; the bench resolves the wire levels.
*/
`default_nettype none

module bus_master (
  // Resolved data line level
  input wire logic sda,
  // Pulls, high drives the line low
  output logic scl_low,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  import tws_pkg::*;

  // Half bit period; keep a multiple of 4 ns to stay off clock edges
  int half_ns = 400;

  // Lines released: bus idle
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // START from an idle bus, then clock low
  task automatic cond_start;
    sda_low = 1'b1;
    #(half_ns);
    scl_low = 1'b1;
    #(half_ns);
  endtask : cond_start

  // Repeated START without releasing the bus
  task automatic cond_rstart;
    sda_low = 1'b0;
    #(half_ns);
    scl_low = 1'b0;
    #(half_ns);
    sda_low = 1'b1;
    #(half_ns);
    scl_low = 1'b1;
    #(half_ns);
  endtask : cond_rstart

  // STOP, leaving both lines high
  task automatic cond_stop;
    sda_low = 1'b1;
    #(half_ns);
    scl_low = 1'b0;
    #(half_ns);
    sda_low = 1'b0;
    #(half_ns);
  endtask : cond_stop

  // One clock pulse; data changes only while the clock is low
  task automatic bit_xfer(input logic drive, output logic seen);
    sda_low = !drive;
    #(half_ns);
    scl_low = 1'b0;
    #(half_ns);
    seen = sda;
    scl_low = 1'b1;
  endtask : bit_xfer

  // Byte MSB first, then the acknowledge slot
  task automatic put_byte(input byte_t b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], s);
    end
    bit_xfer(1'b1, s);
    ack = !s;
  endtask : put_byte

  // Read a byte; acknowledge it only when ack is high
  task automatic get_byte(input logic ack, output byte_t b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, s);
      b[i] = s;
    end
    bit_xfer(!ack, s);
  endtask : get_byte
endmodule : bus_master

`default_nettype wire

// >>> verification/two_wire_slave_port_test.sv
/*
  Self-checking bench for two_wire_slave_port with a bus master model.
  Assumes tws_pkg, the design and bus_master are compiled before it.
*/
`default_nettype none

module two_wire_slave_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import tws_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk, sys_rst, link_clk, scl_low, sda_low, sda_o, sda_oe, nv_busy;
  logic tx_load, tx_ready, tx_taken, rx_valid, addr_hit, addr_rd, xfer_end, ack;
  dev_addr_t nv_dev_addr;
  byte_t tx_byte, rx_byte, last_rx, d;
  wire logic scl_i, sda_i;
  int n_fail, checks_done, n_hit, n_end, n_taken, h0, e0, t0;
  // One row: control byte, configured address, busy, acknowledge due
  typedef struct {byte_t ctl; dev_addr_t nv; logic busy; logic ack;} row_t;
  row_t rows [5] = '{'{8'hA0, 3'h5, 1'b0, 1'b1}, '{8'hAA, 3'h5, 1'b0, 1'b1},
    '{8'hA6, 3'h5, 1'b0, 1'b0}, '{8'hB0, 3'h5, 1'b0, 1'b0}, '{8'hA0, 3'h5, 1'b1, 1'b0}};

  // Pull-ups: a line is low while anyone pulls it
  assign scl_i = !scl_low;
  assign sda_i = !(sda_low || (sda_oe && !sda_o));

  two_wire_slave_port two_wire_slave_port_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .nv_dev_addr(nv_dev_addr), .nv_busy(nv_busy), .tx_byte(tx_byte), .tx_load(tx_load),
    .tx_ready(tx_ready), .tx_taken(tx_taken), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .addr_hit(addr_hit), .addr_rd(addr_rd), .xfer_end(xfer_end));
  bus_master bus_master_i (.sda(sda_i), .scl_low(scl_low), .sda_low(sda_low));

  // ----------------------------------------------------------------
  // Clocks and event counters
  // ----------------------------------------------------------------
  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;
  // Link clock offset so its edges never meet the master's edges
  initial begin
    link_clk = 1'b0;
    #17;
    forever #40 link_clk = ~link_clk;
  end
  // Count one-cycle event pulses
  always @(posedge core_clk) begin
    if (addr_hit === 1'b1) n_hit++;
    if (xfer_end === 1'b1) n_end++;
    if (tx_taken === 1'b1) n_taken++;
    if (rx_valid === 1'b1) last_rx = rx_byte;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Hand a byte to the transmit path once it can take one
  task automatic load_tx(input byte_t b);
    int k;
    k = 0;
    while (tx_ready !== 1'b1 && k < 500) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    check("tx_ready", 8'h01, {7'h00, tx_ready});
    tx_byte = b;
    tx_load = 1'b1;
    @(posedge core_clk);
    #1;
    tx_load = 1'b0;
  endtask : load_tx

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Cuts a hang short; the tests need about 210 us
  initial begin
    #300000;
    n_fail++;
    $display("Error watchdog expected end seen hang");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, nv_busy, tx_load, tx_byte, nv_dev_addr} = {1'b1, 1'b0, 1'b0, 8'h00, 3'h5};
    // Held past four link periods so the link side sees it
    repeat (100) @(posedge core_clk);
    #1;
    check("tx_ready in reset", 8'h00, {7'h00, tx_ready});
    sys_rst = 1'b0;
    repeat (120) @(posedge core_clk);
    #1;
    // Ordinary writes: address matching, busy and type code
    foreach (rows[i]) begin
      nv_dev_addr = rows[i].nv;
      nv_busy = rows[i].busy;
      {h0, e0} = {n_hit, n_end};
      bus_master_i.cond_start();
      bus_master_i.put_byte(rows[i].ctl, ack);
      check("address ack", {7'h00, rows[i].ack}, {7'h00, ack});
      if (rows[i].ack) begin
        bus_master_i.put_byte(8'h5A ^ 8'(i), ack);
        check("data ack", 8'h01, {7'h00, ack});
        check("rx_byte", 8'h5A ^ 8'(i), last_rx);
      end
      bus_master_i.cond_stop();
      @(posedge core_clk);
      #1;
      check("hits", {7'h00, rows[i].ack}, 8'(n_hit - h0));
      check("ends", {7'h00, rows[i].ack}, 8'(n_end - e0));
      nv_busy = 1'b0;
      $display("row %0d done", i);
    end
    // Write, repeated START, two-byte read, near 400 kHz
    bus_master_i.half_ns = 1260;
    load_tx(8'h3C);
    {e0, t0} = {n_end, n_taken};
    bus_master_i.cond_start();
    bus_master_i.put_byte(8'hA0, ack);
    bus_master_i.put_byte(8'h11, ack);
    bus_master_i.cond_rstart();
    bus_master_i.put_byte(8'hA1, ack);
    check("read address ack", 8'h01, {7'h00, ack});
    fork
      bus_master_i.get_byte(1'b1, d);
      begin
        #5040;
        load_tx(8'hC3);
      end
    join
    check("first read byte", 8'h3C, d);
    bus_master_i.get_byte(1'b0, d);
    check("last read byte", 8'hC3, d);
    bus_master_i.cond_stop();
    @(posedge core_clk);
    #1;
    check("bytes taken", 8'h02, 8'(n_taken - t0));
    // Not-acknowledge already closed the read, so only the restart ends one
    check("ends", 8'h01, 8'(n_end - e0));
    check("addr_rd", 8'h01, {7'h00, addr_rd});
    $display("read test done");
    // STOP in mid-byte, START while sending, then a normal address
    bus_master_i.half_ns = 400;
    h0 = n_hit;
    bus_master_i.cond_start();
    for (int i = 0; i < 4; i++) bus_master_i.bit_xfer(i[0] == 1'b0, ack);
    bus_master_i.cond_stop();
    check("released", 8'h00, {7'h00, sda_oe});
    bus_master_i.cond_start();
    bus_master_i.put_byte(8'hA1, ack);
    bus_master_i.cond_rstart();
    bus_master_i.put_byte(8'hA0, ack);
    check("ack after abort", 8'h01, {7'h00, ack});
    bus_master_i.cond_stop();
    @(posedge core_clk);
    #1;
    check("hits", 8'h02, 8'(n_hit - h0));
    $display("abort test done");
    print_verdict();
  end
endmodule : two_wire_slave_port_test

`default_nettype wire
